// [irq_enable_regs.sv]
/*
 Enable registers five and six with their source gating.
 Assumes a one-cycle register port and flags synchronous to clk_sys_in.
*/
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module irq_enable_regs (
	input  wire logic                                clk_sys_in,
	input  wire logic                                arst_n_in,
	input  wire logic [irq_enable_pkg::ADDR_W-1:0]   addr_in,
	input  wire logic [irq_enable_pkg::REG_W-1:0]    wdata_in,
	input  wire logic                                wr_in,
	input  wire logic                                rd_in,
	output logic      [irq_enable_pkg::REG_W-1:0]    rdata_out,
	input  wire logic                                otg_pend_in,
	input  wire logic                                twi3_master_pend_in,
	input  wire logic                                twi3_slave_pend_in,
	input  wire logic                                serial3_tx_pend_in,
	input  wire logic                                serial3_rx_pend_in,
	input  wire logic                                serial3_err_pend_in,
	input  wire logic                                graphics_pend_in,
	output logic                                     otg_req_out,
	output logic                                     twi3_master_req_out,
	output logic                                     twi3_slave_req_out,
	output logic                                     serial3_tx_req_out,
	output logic                                     serial3_rx_req_out,
	output logic                                     serial3_err_req_out,
	output logic                                     graphics_req_out
);
	logic [15:0] irq_enable_reg5_r;
	logic [15:0] irq_enable_reg5_nxt;
	logic [15:0] irq_enable_reg6_r;
	logic [15:0] irq_enable_reg6_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic [6:0]  pend;
	logic [6:0]  en;
	logic [6:0]  req;

	always_comb begin
		irq_enable_reg5_nxt = irq_enable_reg5_r;
		irq_enable_reg6_nxt = irq_enable_reg6_r;
		rdata_nxt           = 16'h0000;
		if (wr_in && addr_in == irq_enable_pkg::IDX_REG5) begin
			// Masking keeps unused bits at zero
			irq_enable_reg5_nxt = wdata_in & irq_enable_pkg::MASK_REG5;
		end
		if (wr_in && addr_in == irq_enable_pkg::IDX_REG6) begin
			irq_enable_reg6_nxt = wdata_in & irq_enable_pkg::MASK_REG6;
		end
		if (rd_in) begin
			if (addr_in == irq_enable_pkg::IDX_REG5) begin
				rdata_nxt = irq_enable_reg5_r;
			end else if (addr_in == irq_enable_pkg::IDX_REG6) begin
				rdata_nxt = irq_enable_reg6_r;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_enable_reg5_r <= irq_enable_pkg::RST_VAL;
			irq_enable_reg6_r <= irq_enable_pkg::RST_VAL;
			rdata_r           <= irq_enable_pkg::RST_VAL;
		end else begin
			irq_enable_reg5_r <= irq_enable_reg5_nxt;
			irq_enable_reg6_r <= irq_enable_reg6_nxt;
			rdata_r           <= rdata_nxt;
		end
	end

	assign rdata_out = rdata_r;

	// Source order: otg, master, slave, tx, rx, err, graphics
	assign pend = {graphics_pend_in, serial3_err_pend_in, serial3_rx_pend_in,
		serial3_tx_pend_in, twi3_slave_pend_in, twi3_master_pend_in, otg_pend_in};
	assign en[0] = irq_enable_reg5_r[irq_enable_pkg::BIT_OTG];
	assign en[1] = irq_enable_reg5_r[irq_enable_pkg::BIT_TWI3_M];
	assign en[2] = irq_enable_reg5_r[irq_enable_pkg::BIT_TWI3_S];
	assign en[3] = irq_enable_reg5_r[irq_enable_pkg::BIT_SER3_TX];
	assign en[4] = irq_enable_reg5_r[irq_enable_pkg::BIT_SER3_RX];
	assign en[5] = irq_enable_reg5_r[irq_enable_pkg::BIT_SER3_ER];
	assign en[6] = irq_enable_reg6_r[irq_enable_pkg::BIT_GFX];

	irq_gate #(
		.N (irq_enable_pkg::NUM_SRC)
	) irq_gate_i (
		.pend_in (pend),
		.en_in   (en),
		.req_out (req)
	);

	assign otg_req_out         = req[0];
	assign twi3_master_req_out = req[1];
	assign twi3_slave_req_out  = req[2];
	assign serial3_tx_req_out  = req[3];
	assign serial3_rx_req_out  = req[4];
	assign serial3_err_req_out = req[5];
	assign graphics_req_out    = req[6];

	// Sampled values on both sides, so the comb path shows no race here
	property p_gate_and;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		otg_req_out == (otg_pend_in && irq_enable_reg5_r[irq_enable_pkg::BIT_OTG]);
	endproperty
	a_gate_and: assert property (p_gate_and) else $error("otg gate wrong");

	property p_otg_wr;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5) |=>
			irq_enable_reg5_r[irq_enable_pkg::BIT_OTG] ==
			$past(wdata_in[irq_enable_pkg::BIT_OTG]);
	endproperty
	a_otg_wr: assert property (p_otg_wr) else $error("otg enable not written");

	property p_twi_m;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5 &&
			!wdata_in[irq_enable_pkg::BIT_TWI3_M]) ##1 twi3_master_pend_in
			|-> !twi3_master_req_out;
	endproperty
	a_twi_m: assert property (p_twi_m) else $error("master request leaked");

	property p_twi_m_gate;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		twi3_master_req_out ==
			(twi3_master_pend_in && irq_enable_reg5_r[irq_enable_pkg::BIT_TWI3_M]);
	endproperty
	a_twi_m_gate: assert property (p_twi_m_gate) else $error("master gate wrong");

	property p_twi_m_wr;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5) |=>
			irq_enable_reg5_r[irq_enable_pkg::BIT_TWI3_M] ==
			$past(wdata_in[irq_enable_pkg::BIT_TWI3_M]);
	endproperty
	a_twi_m_wr: assert property (p_twi_m_wr) else $error("master enable not written");

	property p_twi_s;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5 &&
			wdata_in[irq_enable_pkg::BIT_TWI3_S]) ##1 twi3_slave_pend_in
			|-> twi3_slave_req_out;
	endproperty
	a_twi_s: assert property (p_twi_s) else $error("slave request blocked");

	property p_twi_s_gate;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		twi3_slave_req_out ==
			(twi3_slave_pend_in && irq_enable_reg5_r[irq_enable_pkg::BIT_TWI3_S]);
	endproperty
	a_twi_s_gate: assert property (p_twi_s_gate) else $error("slave gate wrong");

	property p_twi_s_wr;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5) |=>
			irq_enable_reg5_r[irq_enable_pkg::BIT_TWI3_S] ==
			$past(wdata_in[irq_enable_pkg::BIT_TWI3_S]);
	endproperty
	a_twi_s_wr: assert property (p_twi_s_wr) else $error("slave enable not written");

	property p_err;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		serial3_err_req_out ==
			(serial3_err_pend_in && irq_enable_reg5_r[irq_enable_pkg::BIT_SER3_ER]);
	endproperty
	a_err: assert property (p_err) else $error("error gate wrong");

	property p_err_wr;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5) |=>
			irq_enable_reg5_r[irq_enable_pkg::BIT_SER3_ER] ==
			$past(wdata_in[irq_enable_pkg::BIT_SER3_ER]);
	endproperty
	a_err_wr: assert property (p_err_wr) else $error("error enable not written");

	property p_gfx;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG6) |=>
			irq_enable_reg6_r == ($past(wdata_in) & irq_enable_pkg::MASK_REG6);
	endproperty
	a_gfx: assert property (p_gfx) else $error("register six write wrong");

	property p_rd6;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(rd_in && addr_in == irq_enable_pkg::IDX_REG6) |=>
			rdata_out == $past(irq_enable_reg6_r);
	endproperty
	a_rd6: assert property (p_rd6) else $error("register six read wrong");

	property p_unimpl;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(rd_in && addr_in == irq_enable_pkg::IDX_REG5) |=>
			(rdata_out & ~irq_enable_pkg::MASK_REG5) == 16'h0000;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unused bit read nonzero");

	property p_unimpl6;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(rd_in && addr_in == irq_enable_pkg::IDX_REG6) |=>
			(rdata_out & ~irq_enable_pkg::MASK_REG6) == 16'h0000;
	endproperty
	a_unimpl6: assert property (p_unimpl6) else $error("unused six bit read nonzero");

	property p_reg5_mask;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5) |=>
			irq_enable_reg5_r == ($past(wdata_in) & irq_enable_pkg::MASK_REG5);
	endproperty
	a_reg5_mask: assert property (p_reg5_mask) else $error("register five write wrong");

	// Unused word indices must neither store nor return anything
	property p_rd_other;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(rd_in && addr_in != irq_enable_pkg::IDX_REG5 &&
			addr_in != irq_enable_pkg::IDX_REG6) |=> rdata_out == 16'h0000;
	endproperty
	a_rd_other: assert property (p_rd_other) else $error("unused index read nonzero");

	property p_readback;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5) ##1
			(rd_in && addr_in == irq_enable_pkg::IDX_REG5 && !wr_in) |=>
			rdata_out == ($past(wdata_in, 2) & irq_enable_pkg::MASK_REG5);
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	property p_rd5;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(rd_in && addr_in == irq_enable_pkg::IDX_REG5) |=>
			rdata_out == $past(irq_enable_reg5_r);
	endproperty
	a_rd5: assert property (p_rd5) else $error("register five read wrong");

	property p_hold5;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		!(wr_in && addr_in == irq_enable_pkg::IDX_REG5) |=> $stable(irq_enable_reg5_r);
	endproperty
	a_hold5: assert property (p_hold5) else $error("register five changed unwritten");

	property p_hold6;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		!(wr_in && addr_in == irq_enable_pkg::IDX_REG6) |=> $stable(irq_enable_reg6_r);
	endproperty
	a_hold6: assert property (p_hold6) else $error("register six changed unwritten");

	// Read data stand one cycle only, so a stale word never looks fresh
	property p_rd_idle;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		!rd_in |=> rdata_out == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

	// No disable here: this one watches the reset itself
	property p_reset;
		@(posedge clk_sys_in)
		!arst_n_in |=> irq_enable_reg5_r == irq_enable_pkg::RST_VAL &&
			irq_enable_reg6_r == irq_enable_pkg::RST_VAL &&
			rdata_out == irq_enable_pkg::RST_VAL;
	endproperty
	a_reset: assert property (p_reset) else $error("reset value wrong");

	property p_reset_req;
		@(posedge clk_sys_in)
		!arst_n_in |=> !(otg_req_out || twi3_master_req_out || twi3_slave_req_out ||
			serial3_tx_req_out || serial3_rx_req_out || serial3_err_req_out ||
			graphics_req_out);
	endproperty
	a_reset_req: assert property (p_reset_req) else $error("request after reset");

	property p_rxtx;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		{serial3_tx_req_out, serial3_rx_req_out} ==
			{serial3_tx_pend_in && irq_enable_reg5_r[irq_enable_pkg::BIT_SER3_TX],
			serial3_rx_pend_in && irq_enable_reg5_r[irq_enable_pkg::BIT_SER3_RX]};
	endproperty
	a_rxtx: assert property (p_rxtx) else $error("serial gate wrong");

	property p_tx_wr;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5) |=>
			irq_enable_reg5_r[irq_enable_pkg::BIT_SER3_TX] ==
			$past(wdata_in[irq_enable_pkg::BIT_SER3_TX]);
	endproperty
	a_tx_wr: assert property (p_tx_wr) else $error("transmit enable not written");

	property p_rx_wr;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		(wr_in && addr_in == irq_enable_pkg::IDX_REG5) |=>
			irq_enable_reg5_r[irq_enable_pkg::BIT_SER3_RX] ==
			$past(wdata_in[irq_enable_pkg::BIT_SER3_RX]);
	endproperty
	a_rx_wr: assert property (p_rx_wr) else $error("receive enable not written");

	property p_comb;
		@(posedge clk_sys_in) disable iff (!arst_n_in)
		graphics_req_out ==
			(graphics_pend_in && irq_enable_reg6_r[irq_enable_pkg::BIT_GFX]);
	endproperty
	a_comb: assert property (p_comb) else $error("graphics gate wrong");

	c_wr5: cover property (@(posedge clk_sys_in) wr_in && addr_in == irq_enable_pkg::IDX_REG5);
	c_rd6: cover property (@(posedge clk_sys_in) rd_in && addr_in == irq_enable_pkg::IDX_REG6);
	c_gfx: cover property (@(posedge clk_sys_in) graphics_req_out);
	c_otg: cover property (@(posedge clk_sys_in) otg_req_out);
	c_b2b: cover property (@(posedge clk_sys_in) wr_in ##1 rd_in);
endmodule

// [irq_enable_pkg.sv]
/*
 Package for the interrupt-enable block covering enable registers five and six.
 Assumes a 16-bit register port with word indices chosen by this block.
*/
package irq_enable_pkg;
	localparam int unsigned REG_W       = 16;
	localparam int unsigned ADDR_W      = 4;
	localparam logic [3:0]  IDX_REG5    = 4'h0;
	localparam logic [3:0]  IDX_REG6    = 4'h1;
	localparam int unsigned BIT_OTG     = 6;
	localparam int unsigned BIT_TWI3_M  = 5;
	localparam int unsigned BIT_TWI3_S  = 4;
	localparam int unsigned BIT_SER3_TX = 3;
	localparam int unsigned BIT_SER3_RX = 2;
	localparam int unsigned BIT_SER3_ER = 1;
	localparam int unsigned BIT_GFX     = 4;
	localparam int unsigned NUM_SRC     = 7;
	localparam logic [15:0] MASK_REG5   = 16'h007e;
	localparam logic [15:0] MASK_REG6   = 16'h0010;
	localparam logic [15:0] RST_VAL     = 16'h0000;
endpackage

// [irq_gate.sv]
/*
 Per-source gate: pending flag AND enable bit.
 Assumes flags are synchronous to the system clock.
*/
`timescale 1ns/1ns
module irq_gate #(
	parameter int unsigned N = 7
) (
	input  wire logic [N-1:0] pend_in,
	input  wire logic [N-1:0] en_in,
	output logic      [N-1:0] req_out
);
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_src
			assign req_out[i] = pend_in[i] & en_in[i];
		end
	endgenerate
endmodule

// [irq_enable_regs_5_6_bench.sv]
/*
 Self-checking bench for the enable registers five and six with their gating.
 Assumes the one-cycle register port and combinational request gating.
*/
`timescale 1ns/1ns
module irq_enable_regs_5_6_bench;
	logic        clk_sys_in = 1'b0;
	logic        arst_n_in  = 1'b0;
	logic [3:0]  addr_in    = 4'h0;
	logic [15:0] wdata_in   = 16'h0000;
	logic        wr_in      = 1'b0;
	logic        rd_in      = 1'b0;
	logic [15:0] rdata_out;
	logic [6:0]  pend       = 7'h00;
	logic [6:0]  req;
	logic [15:0] m5         = 16'h0000;
	logic [15:0] m6         = 16'h0000;
	logic [15:0] rnd        = 16'h0041;
	int          num_errors = 0;
	int          compares   = 0;

	always #50 clk_sys_in = ~clk_sys_in;

	irq_enable_regs irq_enable_regs_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .otg_pend_in(pend[6]), .twi3_master_pend_in(pend[5]),
		.twi3_slave_pend_in(pend[4]), .serial3_tx_pend_in(pend[3]),
		.serial3_rx_pend_in(pend[2]), .serial3_err_pend_in(pend[1]),
		.graphics_pend_in(pend[0]), .otg_req_out(req[6]), .twi3_master_req_out(req[5]),
		.twi3_slave_req_out(req[4]), .serial3_tx_req_out(req[3]),
		.serial3_rx_req_out(req[2]), .serial3_err_req_out(req[1]),
		.graphics_req_out(req[0]));

	// Taps give a maximal-length 16-bit sequence
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// Enable order matches pend: otg, master, slave, tx, rx, err, graphics
	function automatic logic [6:0] exp_req(input logic [15:0] r5, input logic [15:0] r6,
			input logic [6:0] p);
		return p & {r5[6:1], r6[4]};
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		if (a == irq_enable_pkg::IDX_REG5) m5 = d & irq_enable_pkg::MASK_REG5;
		if (a == irq_enable_pkg::IDX_REG6) m6 = d & irq_enable_pkg::MASK_REG6;
	endtask

	// Also checks that read data stands for one cycle only
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 check("rdata", exp, rdata_out);
		@(posedge clk_sys_in);
		#1 check("rdata idle", 16'h0000, rdata_out);
	endtask

	function automatic logic [15:0] exp_rd(input logic [3:0] a, input logic [15:0] r5,
			input logic [15:0] r6);
		if (a == irq_enable_pkg::IDX_REG5) return r5;
		if (a == irq_enable_pkg::IDX_REG6) return r6;
		return 16'h0000;
	endfunction

	// Write then read with no gap, as the bus allows
	task automatic wr_rd(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
		rd_in <= 1'b1;
		if (a == irq_enable_pkg::IDX_REG5) m5 = d & irq_enable_pkg::MASK_REG5;
		if (a == irq_enable_pkg::IDX_REG6) m6 = d & irq_enable_pkg::MASK_REG6;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 check("rdata after write", exp_rd(a, m5, m6), rdata_out);
	endtask

	task automatic gate(input logic [6:0] p);
		@(posedge clk_sys_in);
		pend <= p;
		#1 check("req", {9'h000, exp_req(m5, m6, p)}, {9'h000, req});
	endtask

	task automatic tally_and_finish;
		$display("Comparisons %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		gate(7'h7f);
		rd(irq_enable_pkg::IDX_REG5, 16'h0000);
		rd(irq_enable_pkg::IDX_REG6, 16'h0000);
		wr(irq_enable_pkg::IDX_REG5, 16'hffff);
		wr(irq_enable_pkg::IDX_REG6, 16'hffff);
		wr(4'h2, 16'hffff);
		rd(irq_enable_pkg::IDX_REG5, 16'h007e);
		rd(irq_enable_pkg::IDX_REG6, 16'h0010);
		rd(4'h2, 16'h0000);
		// One-hot flags with every enable set pin each flag to its own request
		gate(7'h40);
		gate(7'h20);
		gate(7'h10);
		gate(7'h08);
		gate(7'h04);
		gate(7'h02);
		gate(7'h01);
		// Back-to-back write and read with only unused bits set
		wr_rd(irq_enable_pkg::IDX_REG5, 16'hff81);
		wr_rd(irq_enable_pkg::IDX_REG6, 16'hffef);
		gate(7'h7f);
		wr_rd(irq_enable_pkg::IDX_REG6, 16'h0010);
		for (int i = 0; i < 60; i++) begin
			rnd = lfsr(rnd);
			wr({2'b00, rnd[1:0]}, lfsr(rnd));
			gate(rnd[8:2]);
			rd({2'b00, rnd[1:0]}, rnd[1] ? 16'h0000 : (rnd[0] ? m6 : m5));
			wr_rd({2'b00, rnd[10:9]}, lfsr(lfsr(rnd)));
		end
		// Reset in mid-run must mask every source again
		@(posedge clk_sys_in);
		arst_n_in <= 1'b0;
		@(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		m5 = 16'h0000;
		m6 = 16'h0000;
		gate(7'h7f);
		rd(irq_enable_pkg::IDX_REG5, 16'h0000);
		rd(irq_enable_pkg::IDX_REG6, 16'h0000);
		tally_and_finish();
	end
endmodule
